// [exec_cfg.svh]
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// Bit positions inside the status flag byte.
`define FLAG_C 3'd0
`define FLAG_Z 3'd1
`define FLAG_N 3'd2
`define FLAG_V 3'd3
`define FLAG_S 3'd4
`define FLAG_H 3'd5
`define FLAG_T 3'd6
`define FLAG_I 3'd7

// Execution lengths in core clock cycles.
`define CYC_SHORT 2'd1
`define CYC_BRANCH_TAKEN 2'd2
`define CYC_SKIP_ONE 2'd2
`define CYC_SKIP_TWO 2'd3
`define CYC_DATA_ACCESS 2'd2
`define CYC_FAST_WRITE 2'd1
`define CYC_CODE_READ 2'd3
`define CYC_CODE_WRITE 2'd1

// Program counter and pointer steps.
`define PC_STEP 2'd1
`define PC_SKIP_ONE 2'd2
`define PC_SKIP_TWO 2'd3
`define PTR_STEP 16'h0001
`define CODE_WRITE_STEP 16'h0002
`define FAR_STEP 24'h000001
`define REG_R0 5'h00

`endif

// [exec_pkg.sv]
package exec_pkg;

  typedef enum logic [4:0] {
    OP_NONE, OP_EQUAL_SKIP, OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP,
    OP_IO_BIT_CLEAR_SKIP, OP_IO_BIT_SET_SKIP, OP_BRANCH,
    OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM,
    OP_DIRECT_DATA_READ, OP_POINTER_READ, OP_OFFSET_POINTER_READ,
    OP_DIRECT_DATA_WRITE, OP_POINTER_WRITE, OP_OFFSET_POINTER_WRITE,
    OP_CODE_MEMORY_READ, OP_FAR_CODE_MEMORY_READ, OP_CODE_MEMORY_WRITE
  } op_e;

  typedef enum logic [3:0] {
    COND_FLAG_SET, COND_FLAG_CLEAR, COND_SIGNED_GE, COND_SIGNED_LESS,
    COND_HIGHER_SAME, COND_BELOW, COND_HALF_SET, COND_HALF_CLEAR,
    COND_IRQ_ENABLED, COND_IRQ_DISABLED, COND_TBIT_SET, COND_TBIT_CLEAR,
    COND_OVF_SET, COND_OVF_CLEAR
  } cond_e;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_sel_e;
  typedef enum logic [1:0] {MODE_PLAIN, MODE_POST_INC, MODE_PRE_DEC} ptr_mode_e;

  typedef struct packed {
    op_e op;
    cond_e cond;
    ptr_sel_e ptr_sel;
    ptr_mode_e ptr_mode;
    logic implied_r0;
    logic [4:0] dst;
    logic [2:0] bit_sel;
    logic signed [6:0] branch_k;
    logic [5:0] disp;
    logic [7:0] imm;
    logic [15:0] addr;
  } instr_s;

  typedef struct packed {
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [15:0] ptr_x;
    logic [15:0] ptr_y;
    logic [15:0] ptr_z;
    logic [15:0] pair_r1r0;
    logic [7:0] code_high;
    logic [7:0] flags;
    logic [7:0] io_val;
    logic next_two_word;
  } operands_s;

  typedef struct packed {logic re; logic we; logic [15:0] addr; logic [7:0] wdata;} dmem_req_s;
  typedef struct packed {logic re; logic we; logic [23:0] addr; logic [15:0] wdata;} pmem_req_s;
  typedef struct packed {logic we; logic [4:0] addr; logic [7:0] data;} reg_wb_s;
  typedef struct packed {
    logic we;
    ptr_sel_e sel;
    logic [15:0] value;
    logic high_we;
    logic [7:0] high_value;
  } ptr_wb_s;
  typedef struct packed {logic we; logic [7:0] value;} flag_wb_s;

endpackage : exec_pkg

// [cpu_branch_and_transfer_exec.sv]
`timescale 1ns/1ps
`include "exec_cfg.svh"
// Overview of operation
// RULE_01 - Equal-skip compares two registers; equal skips next instruction, PC+2 or +3.
// RULE_02 - Register-bit skips test one register bit, skipping when clear or set.
// RULE_03 - I/O-bit skips test one I/O bit, skipping when clear or set.
// RULE_04 - Flag branches test a chosen status bit; on match PC becomes PC+k+1.
// RULE_05 - Signed ge branch taken when N xor V is 0; less when 1.
// RULE_06 - Higher-same branch taken on carry 0, below branch on carry 1.
// RULE_07 - Half-carry branches follow H set or clear.
// RULE_08 - Interrupt-state branches follow the global interrupt flag.
// RULE_09 - T-bit branches follow the T flag set or clear.
// RULE_10 - Overflow branches follow the V flag set or clear.
// RULE_11 - Direct data read loads byte at address k, two cycles, flags untouched.
// RULE_12 - Post-increment pointer reads use the pointer, then add one to it.
// RULE_13 - Pre-decrement pointer reads subtract one first, then read there.
// RULE_14 - Offset pointer reads use Y or Z plus q, pointer unchanged.
// RULE_15 - Direct data write stores register at address k, two cycles.
// RULE_16 - Post-increment pointer writes store at pointer, then add one.
// RULE_17 - Pre-decrement pointer writes subtract one, then store there.
// RULE_18 - Offset pointer writes store at Y or Z plus q, pointer unchanged.
// RULE_19 - Code reads fetch byte at Z into R0 or a register, three cycles.
// RULE_20 - Far code reads use high byte joined to Z; post-increment bumps both.
// RULE_21 - Code writes store R1:R0 at the far address; post-increment adds two to Z.
// RULE_22 - Compares only update Z, C, N, V, S, H and never write a register.
module cpu_branch_and_transfer_exec
  import exec_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic issue_i,
  output logic ready_o,
  input wire instr_s instr_i,
  input wire operands_s opnd_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [7:0] dmem_rdata_i,
  input wire logic [7:0] pmem_rdata_i,
  output dmem_req_s dmem_o,
  output pmem_req_s pmem_o,
  output reg_wb_s reg_wb_o,
  output ptr_wb_s ptr_wb_o,
  output flag_wb_s flag_wb_o,
  output logic pc_we_o,
  output logic [PC_W-1:0] pc_next_o,
  output logic done_o
);

  typedef enum logic {ST_IDLE, ST_RUN} state_e;

  // The program counter is at most 22 bits wide in this family of cores.
  if (PC_W < 16 || PC_W > 22) begin : g_bad_width
    $error("PC_W must lie between 16 and 22.");
  end

  state_e state_q;
  logic [1:0] cnt_q;
  logic accept;
  logic last_d;
  logic [1:0] cyc_d;
  logic [PC_W-1:0] pc_d;
  logic [PC_W-1:0] pc_q;
  logic skip_d;
  logic [15:0] ptr_v;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [23:0] far_inc;
  dmem_req_s dmem_d;
  pmem_req_s pmem_d;
  ptr_wb_s ptr_d;
  flag_wb_s flag_d;
  logic rd_en_d;
  logic [4:0] rd_dst_d;
  logic rd_en_q;
  logic [4:0] rd_dst_q;
  logic [7:0] code_hold_q;

  // Status flags after a subtraction whose result is thrown away.
  function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic keep_z,
                                           input logic [7:0] old);
    logic [7:0] r;
    logic [7:0] f;
    r = a - b - {7'h00, cin};
    f = old;
    f[`FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    f[`FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    f[`FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[`FLAG_N] = r[7];
    f[`FLAG_S] = r[7] ^ f[`FLAG_V];
    // With carry the zero flag can only stay set, so multi-byte compares chain.
    f[`FLAG_Z] = (r == 8'h00) & (~keep_z | old[`FLAG_Z]);
    return f;
  endfunction : cmp_flags

  // Branch condition decode; every alias except the signed pair resolves to one status bit test; those test N xor V.
  function automatic logic taken(input cond_e c, input logic [7:0] f, input logic [2:0] b);
    logic t;
    t = 1'b0;
    case (c)
      COND_FLAG_SET: t = f[b]; // [RULE_04]
      COND_FLAG_CLEAR: t = ~f[b]; // [RULE_04]
      COND_SIGNED_GE: t = ~(f[`FLAG_N] ^ f[`FLAG_V]); // [RULE_05]
      COND_SIGNED_LESS: t = f[`FLAG_N] ^ f[`FLAG_V]; // [RULE_05]
      COND_HIGHER_SAME: t = ~f[`FLAG_C]; // [RULE_06]
      COND_BELOW: t = f[`FLAG_C]; // [RULE_06]
      COND_HALF_SET: t = f[`FLAG_H]; // [RULE_07]
      COND_HALF_CLEAR: t = ~f[`FLAG_H]; // [RULE_07]
      COND_IRQ_ENABLED: t = f[`FLAG_I]; // [RULE_08]
      COND_IRQ_DISABLED: t = ~f[`FLAG_I]; // [RULE_08]
      COND_TBIT_SET: t = f[`FLAG_T]; // [RULE_09]
      COND_TBIT_CLEAR: t = ~f[`FLAG_T]; // [RULE_09]
      COND_OVF_SET: t = f[`FLAG_V]; // [RULE_10]
      COND_OVF_CLEAR: t = ~f[`FLAG_V]; // [RULE_10]
      default: t = 1'b0;
    endcase
    return t;
  endfunction : taken

  // A new instruction is only taken while nothing is in flight.
  assign ready_o = (state_q == ST_IDLE);
  assign accept = issue_i && ready_o;

  // Decode the issued instruction into its cycle count, target and side effects.
  always_comb begin
    case (instr_i.ptr_sel)
      PTR_X: ptr_v = opnd_i.ptr_x;
      PTR_Y: ptr_v = opnd_i.ptr_y;
      default: ptr_v = opnd_i.ptr_z;
    endcase
    ptr_inc = ptr_v + `PTR_STEP;
    ptr_dec = ptr_v - `PTR_STEP;
    far_inc = {opnd_i.code_high, opnd_i.ptr_z} + `FAR_STEP;
    cyc_d = `CYC_SHORT;
    pc_d = pc_i + PC_W'(`PC_STEP);
    skip_d = 1'b0;
    dmem_d = '0;
    pmem_d = '0;
    ptr_d = '0;
    ptr_d.sel = instr_i.ptr_sel;
    flag_d = '0;
    rd_en_d = 1'b0;
    rd_dst_d = instr_i.dst;
    case (instr_i.op)
      OP_EQUAL_SKIP: skip_d = (opnd_i.rd_val == opnd_i.rr_val); // [RULE_01]
      OP_REG_BIT_CLEAR_SKIP: skip_d = ~opnd_i.rr_val[instr_i.bit_sel]; // [RULE_02]
      OP_REG_BIT_SET_SKIP: skip_d = opnd_i.rr_val[instr_i.bit_sel]; // [RULE_02]
      OP_IO_BIT_CLEAR_SKIP: skip_d = ~opnd_i.io_val[instr_i.bit_sel]; // [RULE_03]
      OP_IO_BIT_SET_SKIP: skip_d = opnd_i.io_val[instr_i.bit_sel]; // [RULE_03]
      OP_BRANCH: begin
        if (taken(instr_i.cond, opnd_i.flags, instr_i.bit_sel)) begin
          cyc_d = `CYC_BRANCH_TAKEN;
          pc_d = pc_i + PC_W'(instr_i.branch_k) + PC_W'(`PC_STEP); // [RULE_04]
        end
      end
      OP_COMPARE, OP_COMPARE_CARRY: begin
        flag_d.we = 1'b1;
        flag_d.value = cmp_flags(opnd_i.rd_val, opnd_i.rr_val,
                                 (instr_i.op == OP_COMPARE_CARRY) & opnd_i.flags[`FLAG_C],
                                 instr_i.op == OP_COMPARE_CARRY, opnd_i.flags); // [RULE_22]
      end
      OP_COMPARE_IMM: begin
        flag_d.we = 1'b1;
        flag_d.value = cmp_flags(opnd_i.rd_val, instr_i.imm, 1'b0, 1'b0, opnd_i.flags); // [RULE_22]
      end
      OP_DIRECT_DATA_READ, OP_DIRECT_DATA_WRITE: begin
        cyc_d = `CYC_DATA_ACCESS;
        dmem_d.addr = instr_i.addr; // [RULE_11] [RULE_15]
        dmem_d.re = (instr_i.op == OP_DIRECT_DATA_READ);
        dmem_d.we = (instr_i.op == OP_DIRECT_DATA_WRITE);
      end
      OP_POINTER_READ, OP_POINTER_WRITE: begin
        cyc_d = `CYC_DATA_ACCESS;
        // The X pointer store path without pre-decrement is a single cycle.
        if (instr_i.op == OP_POINTER_WRITE && instr_i.ptr_sel == PTR_X &&
            instr_i.ptr_mode != MODE_PRE_DEC) begin
          cyc_d = `CYC_FAST_WRITE;
        end
        dmem_d.re = (instr_i.op == OP_POINTER_READ);
        dmem_d.we = (instr_i.op == OP_POINTER_WRITE);
        dmem_d.addr = ptr_v;
        ptr_d.we = (instr_i.ptr_mode != MODE_PLAIN);
        ptr_d.value = ptr_inc; // [RULE_12] [RULE_16]
        if (instr_i.ptr_mode == MODE_PRE_DEC) begin
          dmem_d.addr = ptr_dec; // [RULE_13] [RULE_17]
          ptr_d.value = ptr_dec;
        end
      end
      OP_OFFSET_POINTER_READ, OP_OFFSET_POINTER_WRITE: begin
        cyc_d = `CYC_DATA_ACCESS;
        dmem_d.re = (instr_i.op == OP_OFFSET_POINTER_READ);
        dmem_d.we = (instr_i.op == OP_OFFSET_POINTER_WRITE);
        dmem_d.addr = ptr_v + {10'h000, instr_i.disp}; // [RULE_14] [RULE_18]
      end
      OP_CODE_MEMORY_READ, OP_FAR_CODE_MEMORY_READ: begin
        cyc_d = `CYC_CODE_READ;
        pmem_d.re = 1'b1;
        pmem_d.addr = {8'h00, opnd_i.ptr_z}; // [RULE_19]
        if (instr_i.implied_r0) begin
          rd_dst_d = `REG_R0; // [RULE_19]
        end
        ptr_d.sel = PTR_Z;
        ptr_d.we = (instr_i.ptr_mode == MODE_POST_INC);
        ptr_d.value = opnd_i.ptr_z + `PTR_STEP; // [RULE_19]
        if (instr_i.op == OP_FAR_CODE_MEMORY_READ) begin
          pmem_d.addr = {opnd_i.code_high, opnd_i.ptr_z}; // [RULE_20]
          ptr_d.value = far_inc[15:0]; // [RULE_20]
          ptr_d.high_we = (instr_i.ptr_mode == MODE_POST_INC);
          ptr_d.high_value = far_inc[23:16];
        end
      end
      OP_CODE_MEMORY_WRITE: begin
        cyc_d = `CYC_CODE_WRITE;
        pmem_d.we = 1'b1;
        pmem_d.addr = {opnd_i.code_high, opnd_i.ptr_z}; // [RULE_21]
        pmem_d.wdata = opnd_i.pair_r1r0;
        ptr_d.sel = PTR_Z;
        ptr_d.we = (instr_i.ptr_mode == MODE_POST_INC);
        ptr_d.value = opnd_i.ptr_z + `CODE_WRITE_STEP; // [RULE_21]
      end
      default: cyc_d = `CYC_SHORT;
    endcase
    dmem_d.wdata = opnd_i.rr_val;
    rd_en_d = dmem_d.re | pmem_d.re;
    // Skipping a two-word instruction costs one more cycle than a one-word one.
    if (skip_d) begin
      cyc_d = opnd_i.next_two_word ? `CYC_SKIP_TWO : `CYC_SKIP_ONE; // [RULE_01]
      pc_d = pc_i + PC_W'(opnd_i.next_two_word ? `PC_SKIP_TWO : `PC_SKIP_ONE); // [RULE_01]
    end
  end

  // The final cycle of an instruction is entered from issue or from the count.
  assign last_d = (accept && cyc_d == `CYC_SHORT) || (state_q == ST_RUN && cnt_q == 2'd2);

  // Sequencer: counts the remaining cycles of the instruction in flight.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_RUN;
            cnt_q <= cyc_d;
          end
        end
        ST_RUN: begin
          cnt_q <= cnt_q - 2'd1;
          if (cnt_q == 2'd1) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Memory requests and pointer updates are one-cycle pulses in the first cycle.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      dmem_o <= '0;
      pmem_o <= '0;
      ptr_wb_o <= '0;
      flag_wb_o <= '0;
    end else begin
      dmem_o <= accept ? dmem_d : '0;
      pmem_o <= accept ? pmem_d : '0;
      ptr_wb_o <= accept ? ptr_d : '0;
      flag_wb_o <= accept ? flag_d : '0;
    end
  end

  // Code memory answers in the request cycle; hold it for the third cycle.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      code_hold_q <= 8'h00;
      rd_en_q <= 1'b0;
      rd_dst_q <= 5'h00;
      pc_q <= '0;
    end else begin
      if (pmem_o.re) begin
        code_hold_q <= pmem_rdata_i;
      end
      if (accept) begin
        rd_en_q <= rd_en_d;
        rd_dst_q <= rd_dst_d;
        pc_q <= pc_d;
      end
    end
  end

  // Register write-back, program counter and done all land in the last cycle.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      reg_wb_o <= '0;
      pc_we_o <= 1'b0;
      pc_next_o <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= last_d;
      pc_we_o <= last_d;
      reg_wb_o.we <= last_d && !accept && rd_en_q;
      if (last_d) begin
        pc_next_o <= accept ? pc_d : pc_q;
        reg_wb_o.addr <= rd_dst_q;
        reg_wb_o.data <= dmem_o.re ? dmem_rdata_i : code_hold_q; // [RULE_11] [RULE_19]
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  eq_skip_len_a: assert property (accept && instr_i.op == OP_EQUAL_SKIP && opnd_i.rd_val == opnd_i.rr_val // [RULE_01]
    && !opnd_i.next_two_word |-> ##1 !done_o ##1 done_o && pc_next_o == $past(pc_i, 2) + 2)
    else $error("Equal skip did not advance by two in two cycles.");
  reg_bit_skip_a: assert property (accept && instr_i.op == OP_REG_BIT_CLEAR_SKIP // [RULE_02]
    && opnd_i.rr_val[instr_i.bit_sel] |-> ##1 done_o && pc_next_o == $past(pc_i) + 1)
    else $error("Register bit skip taken on a set bit.");
  io_bit_skip_a: assert property (accept && instr_i.op == OP_IO_BIT_SET_SKIP && opnd_i.next_two_word // [RULE_03]
    && opnd_i.io_val[instr_i.bit_sel] |-> ##1 !done_o ##1 !done_o ##1 done_o && pc_we_o)
    else $error("I/O bit skip over two words did not take three cycles.");
  flag_branch_a: assert property (accept && instr_i.op == OP_BRANCH && instr_i.cond == COND_FLAG_SET // [RULE_04]
    && opnd_i.flags[instr_i.bit_sel] |-> ##2 pc_we_o
    && pc_next_o == PC_W'($past(pc_i, 2) + PC_W'($past(instr_i.branch_k, 2)) + 1))
    else $error("Flag branch target or timing wrong.");
  signed_ge_a: assert property (accept && instr_i.op == OP_BRANCH && instr_i.cond == COND_SIGNED_GE // [RULE_05]
    && (opnd_i.flags[`FLAG_N] ^ opnd_i.flags[`FLAG_V]) |-> ##1 done_o && pc_next_o == $past(pc_i) + 1)
    else $error("Signed ge branch taken with N xor V set.");
  below_branch_a: assert property (accept && instr_i.op == OP_BRANCH && instr_i.cond == COND_BELOW // [RULE_06]
    && opnd_i.flags[`FLAG_C] |-> ##1 !done_o ##1 done_o)
    else $error("Below branch not taken with carry set.");
  half_branch_a: assert property (accept && instr_i.op == OP_BRANCH && instr_i.cond == COND_HALF_CLEAR // [RULE_07]
    && opnd_i.flags[`FLAG_H] |-> ##1 done_o)
    else $error("Half-carry clear branch taken with H set.");
  irq_branch_a: assert property (accept && instr_i.op == OP_BRANCH && instr_i.cond == COND_IRQ_ENABLED // [RULE_08]
    && opnd_i.flags[`FLAG_I] |-> ##1 !done_o ##1 done_o)
    else $error("Interrupt enabled branch not taken.");
  tbit_branch_a: assert property (accept && instr_i.op == OP_BRANCH && instr_i.cond == COND_TBIT_SET // [RULE_09]
    && !opnd_i.flags[`FLAG_T] |-> ##1 done_o)
    else $error("T set branch taken with T clear.");
  ovf_branch_a: assert property (accept && instr_i.op == OP_BRANCH && instr_i.cond == COND_OVF_CLEAR // [RULE_10]
    && !opnd_i.flags[`FLAG_V] |-> ##1 !done_o ##1 done_o)
    else $error("Overflow clear branch not taken.");
  direct_read_a: assert property (accept && instr_i.op == OP_DIRECT_DATA_READ |-> // [RULE_11]
    ##1 dmem_o.re && dmem_o.addr == $past(instr_i.addr) && !flag_wb_o.we
    ##1 done_o && reg_wb_o.we && reg_wb_o.data == $past(dmem_rdata_i))
    else $error("Direct read address, data or timing wrong.");
  post_inc_read_a: assert property (accept && instr_i.op == OP_POINTER_READ && instr_i.ptr_sel == PTR_X // [RULE_12]
    && instr_i.ptr_mode == MODE_POST_INC |-> ##1 dmem_o.addr == $past(opnd_i.ptr_x)
    && ptr_wb_o.we && ptr_wb_o.value == $past(opnd_i.ptr_x) + 16'h0001)
    else $error("Post-increment read used wrong address or step.");
  pre_dec_read_a: assert property (accept && instr_i.op == OP_POINTER_READ && instr_i.ptr_sel == PTR_Y // [RULE_13]
    && instr_i.ptr_mode == MODE_PRE_DEC |-> ##1 dmem_o.addr == $past(opnd_i.ptr_y) - 16'h0001
    && ptr_wb_o.we && ptr_wb_o.value == dmem_o.addr)
    else $error("Pre-decrement read did not use decremented pointer.");
  offset_read_a: assert property (accept && instr_i.op == OP_OFFSET_POINTER_READ && instr_i.ptr_sel == PTR_Z // [RULE_14]
    |-> ##1 !ptr_wb_o.we && dmem_o.addr == $past(opnd_i.ptr_z) + {10'h000, $past(instr_i.disp)})
    else $error("Offset read address wrong or pointer touched.");
  direct_write_a: assert property (accept && instr_i.op == OP_DIRECT_DATA_WRITE |-> // [RULE_15]
    ##1 dmem_o.we && dmem_o.addr == $past(instr_i.addr) && dmem_o.wdata == $past(opnd_i.rr_val)
    ##1 done_o && !reg_wb_o.we)
    else $error("Direct write wrong.");
  post_inc_write_a: assert property (accept && instr_i.op == OP_POINTER_WRITE && instr_i.ptr_sel == PTR_X // [RULE_16]
    && instr_i.ptr_mode == MODE_POST_INC |-> ##1 dmem_o.we && done_o
    && dmem_o.addr == $past(opnd_i.ptr_x) && ptr_wb_o.value == $past(opnd_i.ptr_x) + 16'h0001)
    else $error("Post-increment write wrong.");
  pre_dec_write_a: assert property (accept && instr_i.op == OP_POINTER_WRITE && instr_i.ptr_sel == PTR_Z // [RULE_17]
    && instr_i.ptr_mode == MODE_PRE_DEC |-> ##1 dmem_o.we && dmem_o.addr == $past(opnd_i.ptr_z) - 16'h0001
    ##1 done_o)
    else $error("Pre-decrement write wrong.");
  offset_write_a: assert property (accept && instr_i.op == OP_OFFSET_POINTER_WRITE && instr_i.ptr_sel == PTR_Y // [RULE_18]
    |-> ##1 dmem_o.we && !ptr_wb_o.we && dmem_o.addr == $past(opnd_i.ptr_y) + {10'h000, $past(instr_i.disp)})
    else $error("Offset write wrong.");
  code_read_a: assert property (accept && instr_i.op == OP_CODE_MEMORY_READ && instr_i.implied_r0 |-> // [RULE_19]
    ##1 pmem_o.re && pmem_o.addr == {8'h00, $past(opnd_i.ptr_z)}
    ##2 done_o && reg_wb_o.we && reg_wb_o.addr == 5'h00 && reg_wb_o.data == $past(pmem_rdata_i, 2))
    else $error("Code read to R0 wrong.");
  far_read_a: assert property (accept && instr_i.op == OP_FAR_CODE_MEMORY_READ // [RULE_20]
    && instr_i.ptr_mode == MODE_POST_INC |-> ##1 pmem_o.addr == {$past(opnd_i.code_high), $past(opnd_i.ptr_z)}
    && {ptr_wb_o.high_value, ptr_wb_o.value} == pmem_o.addr + 24'h000001 && ptr_wb_o.high_we ##2 done_o)
    else $error("Far code read wrong.");
  code_write_a: assert property (accept && instr_i.op == OP_CODE_MEMORY_WRITE // [RULE_21]
    && instr_i.ptr_mode == MODE_POST_INC |-> ##1 pmem_o.we && pmem_o.wdata == $past(opnd_i.pair_r1r0)
    && ptr_wb_o.value == $past(opnd_i.ptr_z) + 16'h0002)
    else $error("Code write wrong.");
  compare_a: assert property (accept && instr_i.op == OP_COMPARE && opnd_i.rd_val == opnd_i.rr_val // [RULE_22]
    |-> ##1 flag_wb_o.we && flag_wb_o.value[`FLAG_Z] && !flag_wb_o.value[`FLAG_C] && !reg_wb_o.we && done_o)
    else $error("Compare of equal values wrong.");

  skip_two_c: cover property (accept && skip_d && opnd_i.next_two_word);
  branch_taken_c: cover property (accept && instr_i.op == OP_BRANCH && cyc_d == `CYC_BRANCH_TAKEN);
  far_read_c: cover property (accept && instr_i.op == OP_FAR_CODE_MEMORY_READ ##4 accept);
  pre_dec_c: cover property (accept && instr_i.ptr_mode == MODE_PRE_DEC && dmem_d.we);

endmodule : cpu_branch_and_transfer_exec

// [exec_mem_model.sv]
`timescale 1ns/1ps
module exec_mem_model
  import exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire dmem_req_s dmem_i,
  input wire pmem_req_s pmem_i,
  output logic [7:0] dmem_rdata_o,
  output logic [7:0] pmem_rdata_o
);
  logic [7:0] ram_q [256];
  logic [7:0] last_q;
  // Each byte is seeded from its address, so a wrong address shows up as wrong data.
  initial begin
    for (int i = 0; i < 256; i++) ram_q[i] = i[7:0] ^ 8'h5a;
    last_q = 8'h00;
  end
  // Writes land on the edge; only the low address byte is decoded to keep the model small.
  always @(posedge ref_clk_i) begin
    if (dmem_i.we) ram_q[dmem_i.addr[7:0]] <= dmem_i.wdata;
    if (dmem_i.re) last_q <= dmem_rdata_o;
  end
  // Reads answer at once; either idle bus shows the inverse of the last data-memory byte read, never a stale copy.
  assign dmem_rdata_o = dmem_i.re ? ram_q[dmem_i.addr[7:0]] : ~last_q;
  assign pmem_rdata_o = pmem_i.re ? (pmem_i.addr[7:0] ^ 8'ha5) : ~last_q;
endmodule : exec_mem_model

// [cpu_branch_and_transfer_exec_test.sv]
`timescale 1ns/1ps
module cpu_branch_and_transfer_exec_test;
  import exec_pkg::*;
  typedef struct {op_e op; ptr_sel_e sel; ptr_mode_e mode; int n; logic [23:0] a; logic [15:0] p; logic [7:0] d;} row_s;
  logic ref_clk_i = 0, reset_n_i = 0, issue_i = 0, ready_o, pc_we_o, done_o;
  instr_s ins = '0;
  operands_s opnd = '{8'h33, 8'h33, 16'h0100, 16'h0200, 16'h0300, 16'hbeef, 8'h00, 8'h00, 8'h0f, 1'b0};
  logic [15:0] pc_next_o, spc, sp, ep, pc = 16'h0010;
  logic [7:0] dmem_rdata_i, pmem_rdata_i, sd, sf, sh;
  logic [23:0] sa;
  logic v, t;
  dmem_req_s dmem_o;
  pmem_req_s pmem_o;
  reg_wb_s reg_wb_o;
  ptr_wb_s ptr_wb_o;
  flag_wb_s flag_wb_o;
  int n, n_errors = 0, checked = 0;
  logic [7:0] fls [3] = '{8'h00, 8'hff, 8'h5a};
  logic [2:0] bi [5] = '{3'd0, 3'd5, 3'd7, 3'd6, 3'd3};
  row_s rows [15] = '{
    '{OP_EQUAL_SKIP, PTR_X, MODE_PLAIN, 2, 24'hffffff, 16'hffff, 8'hff},
    '{OP_REG_BIT_CLEAR_SKIP, PTR_X, MODE_PLAIN, 1, 24'hffffff, 16'hffff, 8'hff},
    '{OP_REG_BIT_SET_SKIP, PTR_X, MODE_PLAIN, 2, 24'hffffff, 16'hffff, 8'hff},
    '{OP_IO_BIT_CLEAR_SKIP, PTR_X, MODE_PLAIN, 2, 24'hffffff, 16'hffff, 8'hff},
    '{OP_IO_BIT_SET_SKIP, PTR_X, MODE_PLAIN, 1, 24'hffffff, 16'hffff, 8'hff},
    '{OP_DIRECT_DATA_READ, PTR_X, MODE_PLAIN, 2, 24'h000040, 16'hffff, 8'h1a},
    '{OP_POINTER_READ, PTR_X, MODE_POST_INC, 2, 24'h000100, 16'h0101, 8'h5a},
    '{OP_POINTER_READ, PTR_Y, MODE_PRE_DEC, 2, 24'h0001ff, 16'h01ff, 8'ha5},
    '{OP_OFFSET_POINTER_READ, PTR_Z, MODE_PLAIN, 2, 24'h000305, 16'hffff, 8'h5f},
    '{OP_DIRECT_DATA_WRITE, PTR_X, MODE_PLAIN, 2, 24'h000040, 16'hffff, 8'h33},
    '{OP_POINTER_WRITE, PTR_X, MODE_POST_INC, 1, 24'h000100, 16'h0101, 8'h33},
    '{OP_POINTER_WRITE, PTR_Z, MODE_PRE_DEC, 2, 24'h0002ff, 16'h02ff, 8'h33},
    '{OP_OFFSET_POINTER_WRITE, PTR_Y, MODE_PLAIN, 2, 24'h000205, 16'hffff, 8'h33},
    '{OP_CODE_MEMORY_READ, PTR_Z, MODE_POST_INC, 3, 24'h000300, 16'h0301, 8'ha5},
    '{OP_CODE_MEMORY_WRITE, PTR_Z, MODE_POST_INC, 1, 24'h000300, 16'h0302, 8'hff}};
  cpu_branch_and_transfer_exec i_cpu_branch_and_transfer_exec (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .issue_i(issue_i), .ready_o(ready_o), .instr_i(ins), .opnd_i(opnd), .pc_i(pc),
    .dmem_rdata_i(dmem_rdata_i), .pmem_rdata_i(pmem_rdata_i), .dmem_o(dmem_o), .pmem_o(pmem_o),
    .reg_wb_o(reg_wb_o), .ptr_wb_o(ptr_wb_o), .flag_wb_o(flag_wb_o), .pc_we_o(pc_we_o),
    .pc_next_o(pc_next_o), .done_o(done_o));
  exec_mem_model i_exec_mem_model (.ref_clk_i(ref_clk_i), .dmem_i(dmem_o), .pmem_i(pmem_o),
    .dmem_rdata_o(dmem_rdata_i), .pmem_rdata_o(pmem_rdata_i));
  // The core clock toggles every half period of 12.5 ns.
  always #12.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  // Issues one instruction, then records what the block drives until its done pulse.
  task automatic go(input op_e op, input cond_e c, input ptr_sel_e s, input ptr_mode_e m, input logic [7:0] f);
    @(posedge ref_clk_i);
    ins.op <= op; ins.cond <= c; ins.ptr_sel <= s; ins.ptr_mode <= m; opnd.flags <= f; issue_i <= 1'b1;
    @(posedge ref_clk_i);
    issue_i <= 1'b0;
    n = 0; sa = '1; sp = '1; sd = '1; sf = '1; sh = '1; spc = '1;
    repeat (6) begin
      #1 n++;
      if (dmem_o.re || dmem_o.we) sa = {8'h00, dmem_o.addr};
      if (pmem_o.re || pmem_o.we) sa = pmem_o.addr;
      if (ptr_wb_o.we) sp = ptr_wb_o.value;
      if (ptr_wb_o.high_we) sh = ptr_wb_o.high_value;
      if (reg_wb_o.we) sd = reg_wb_o.data;
      if (dmem_o.we) sd = dmem_o.wdata;
      if (flag_wb_o.we) sf = flag_wb_o.value;
      if (pc_we_o) spc = pc_next_o;
      if (done_o === 1'b1) break;
      @(posedge ref_clk_i);
    end
  endtask : go
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // A hang is cut short far beyond the length of the run.
  initial begin
    #50000 n_errors++;
    conclude();
  end
  initial begin
    ins.bit_sel = 3'd4; ins.branch_k = -7'sd8; ins.disp = 6'h05; ins.addr = 16'h0040; ins.dst = 5'h03;
    ins.imm = 8'h33;
    repeat (2) @(posedge ref_clk_i);
    #1 chk(ready_o === 1'b1 && done_o === 1'b0 && dmem_o === '0, "idle after reset");
    reset_n_i <= 1'b1;
    foreach (rows[i]) begin
      go(rows[i].op, COND_FLAG_SET, rows[i].sel, rows[i].mode, 8'h00);
      ep = (rows[i].op <= OP_IO_BIT_SET_SKIP) ? 16'h0010 + 16'(rows[i].n) : 16'h0011;
      chk(n === rows[i].n && spc === ep && sa === rows[i].a && sp === rows[i].p && sd === rows[i].d,
          $sformatf("row %0d", i));
    end
    // Every condition code against three flag patterns, taken and not taken.
    for (int c = 0; c < 14; c++) begin
      foreach (fls[j]) begin
        v = (c < 2) ? fls[j][4] : (c < 4) ? fls[j][2] ^ fls[j][3] : fls[j][bi[(c - 4) / 2]];
        t = v ^ c[0] ^ (c >= 2 && c <= 5);
        go(OP_BRANCH, cond_e'(c), PTR_X, MODE_PLAIN, fls[j]);
        chk(n === (t ? 2 : 1) && spc === (t ? 16'h0009 : 16'h0011), $sformatf("cond %0d", c));
      end
    end
    // Equal operands: only Z joins the kept T and I bits, and no register is written.
    go(OP_COMPARE, COND_FLAG_SET, PTR_X, MODE_PLAIN, 8'hc0);
    chk(n === 1 && sf === 8'hc2 && sd === 8'hff && spc === 16'h0011, "compare");
    go(OP_COMPARE_CARRY, COND_FLAG_SET, PTR_X, MODE_PLAIN, 8'h03);
    chk(sf === 8'h35, "cmp carry");
    go(OP_COMPARE_IMM, COND_FLAG_SET, PTR_X, MODE_PLAIN, 8'h01);
    chk(sf === 8'h02, "cmp imm");
    // The far pointer wraps from the low word into the high byte.
    opnd.ptr_z = 16'hffff;
    opnd.code_high = 8'h01;
    go(OP_FAR_CODE_MEMORY_READ, COND_FLAG_SET, PTR_Z, MODE_POST_INC, 8'h00);
    chk(n === 3 && sa === 24'h01ffff && sp === 16'h0000 && sh === 8'h02 && sd === 8'h5a, "far read");
    ins.implied_r0 = 1'b1;
    go(OP_CODE_MEMORY_READ, COND_FLAG_SET, PTR_Z, MODE_PLAIN, 8'h00);
    chk(sa === 24'h00ffff && sp === 16'hffff && sd === 8'h5a, "r0 read");
    pc = 16'h1230; opnd.io_val = 8'h10; opnd.next_two_word = 1'b1;
    go(OP_IO_BIT_SET_SKIP, COND_FLAG_SET, PTR_X, MODE_PLAIN, 8'h00);
    chk(n === 3 && spc === 16'h1233, "skip two");
    conclude();
  end
endmodule : cpu_branch_and_transfer_exec_test
